// [ctsc_pkg.sv]
`default_nettype none
package ctsc_pkg;
  // task state word field positions
  localparam int TSW_ENDIAN = 56;
  localparam int TSW_ACCEL_PRES = 52;
  localparam int TSW_ACCEL0 = 48;
  localparam int TSW_AG_LO = 40;
  localparam int TSW_SE_LO = 32;
  localparam int TSW_DBG_MASK = 28;
  localparam int TSW_SUD_LO = 26;
  localparam int TSW_GATE = 25;
  localparam int TSW_GUARD = 24;
  localparam int TSW_TAG_LO = 19;
  localparam int TSW_PRIO_LO = 8;
  localparam int TSW_HDL = 3;
  localparam int TSW_LVL_LO = 0;
  localparam int AG_N = 4;
  localparam int SE_N = 2;
  localparam int TAG_W = 5;
  localparam int PRIO_W = 9;
  localparam int LVL_W = 3;
  localparam int ADDR_W = 48;
  localparam int RP_W = 49;
  localparam int RP_HI_LO = 48;
  localparam int FTZ_BIT = 4;
  localparam int ROUND_SELECT_LO = 0;
  localparam int PREDICTOR_DISABLE_BIT_BIT = 0;
  // field values
  localparam logic [PRIO_W-1:0] PRIO_RST = 9'h1ff;
  localparam logic [PRIO_W-1:0] PRIO_DOUBLE = 9'h1ff;
  localparam logic [PRIO_W-1:0] PRIO_TRIPLE = 9'h1fe;
  localparam logic [PRIO_W-1:0] PRIO_TASK = 9'h0ff;
  localparam logic [LVL_W-1:0] LVL_RST = 3'h5;
  localparam logic [LVL_W-1:0] LVL_SEC_USER = 3'h4;
  localparam logic [LVL_W-1:0] LVL_SEC_SUP = 3'h5;
  localparam logic [1:0] SUD_OFF = 2'h0;
  localparam logic [1:0] SUD_INVASIVE = 2'h1;
  localparam logic [1:0] SUD_NONINV = 2'h2;
  localparam logic GUARD_RST = 1'b1;
  localparam logic FTZ_RST = 1'b1;
  localparam logic PREDICTOR_DISABLE_BIT_RST = 1'b0;
  localparam logic [1:0] ROUND_SELECT_RST = 2'h0;
  localparam logic [15:0] RP_HI_ZERO = 16'h0000;
  localparam logic [15:0] RP_HI_ONES = 16'hffff;
  localparam logic [1:0] RP_ALIGN = 2'h0;
  // move selectors and exception causes
  localparam logic [2:0] SEL_TSW = 3'h0;
  localparam logic [2:0] SEL_RP = 3'h1;
  localparam logic [2:0] SEL_PC = 3'h2;
  localparam logic [2:0] SEL_BP = 3'h3;
  localparam logic [2:0] SEL_FP = 3'h4;
  localparam logic [1:0] EXC_NONE = 2'h0;
  localparam logic [1:0] EXC_PRIV = 2'h1;
  localparam logic [1:0] EXC_WRITE = 2'h2;
  localparam logic [1:0] EXC_UNMAPPED = 2'h3;

  function automatic logic ctsc_rp_ok(input logic [63:0] v);
    ctsc_rp_ok = (v[63:RP_HI_LO] == RP_HI_ZERO || v[63:RP_HI_LO] == RP_HI_ONES)
      && v[1:0] == RP_ALIGN;
  endfunction : ctsc_rp_ok

  function automatic logic ctsc_secure(input logic [LVL_W-1:0] l);
    ctsc_secure = (l == LVL_SEC_USER) || (l == LVL_SEC_SUP);
  endfunction : ctsc_secure
endpackage : ctsc_pkg
`default_nettype wire

// [ctsc_chk_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ctsc_chk_if;
  // checkers clock on the core clock and stay quiet in reset
  logic clk;
  logic rst;
  logic [63:0] rp_wdata;
  logic rp_ok;
  logic evt_valid;
  logic [2:0] evt_level;
  logic evt_secure;
  logic gate;
  logic [2:0] exec_level;
  logic accept;
  modport core(output clk, rst, rp_wdata, evt_valid, evt_level, evt_secure, gate, exec_level,
    input rp_ok, accept);
  modport rp_chk(input clk, rst, rp_wdata, output rp_ok);
  modport evt_chk(input clk, rst, evt_valid, evt_level, evt_secure, gate, exec_level,
    output accept);
endinterface : ctsc_chk_if
`default_nettype wire

// [ctsc_rp_check.sv]
`timescale 1ns/1ps
`default_nettype none
module ctsc_rp_check
  import ctsc_pkg::*;
(
  // checked path
  ctsc_chk_if.rp_chk c
);
  assign c.rp_ok = ctsc_rp_ok(c.rp_wdata);

  // restated with reductions so a broken check function still trips it
  chk_rp_hi_align: assert property (@(posedge c.clk) disable iff (c.rst)
    !c.rp_ok || (c.rp_wdata[1:0] == RP_ALIGN
    && (&c.rp_wdata[63:RP_HI_LO] || ~|c.rp_wdata[63:RP_HI_LO])))
    else $error("return pointer accepted while malformed");
endmodule : ctsc_rp_check
`default_nettype wire

// [ctsc_evt_gate.sv]
`timescale 1ns/1ps
`default_nettype none
module ctsc_evt_gate
  import ctsc_pkg::*;
(
  // gating path
  ctsc_chk_if.evt_chk c
);
  logic sec_block;

  // events at any level other than the current one are dropped; secure mode shuts out non-secure events
  assign sec_block = ctsc_secure(c.exec_level) && !c.evt_secure;
  assign c.accept = c.evt_valid && c.gate && (c.evt_level == c.exec_level)
    && !sec_block;

  chk_evt_secure: assert property (@(posedge c.clk) disable iff (c.rst)
    c.accept |-> c.evt_valid && c.gate && (c.evt_secure || c.exec_level < LVL_SEC_USER
    || c.exec_level > LVL_SEC_SUP))
    else $error("event accepted with gate off or non-secure in secure mode");
endmodule : ctsc_evt_gate
`default_nettype wire

// [ctsc_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - endian bit reports byte order: 0 little, 1 big; read only
// - accelerator-present bit reads 1 when an accelerator is attached
// - accelerator-active bit: reset and detach clear, attach sets, moves ignored
// - four address-generator and two stream-engine bits: close clears, open sets
// - debug mask changed only by block/allow instructions; 1 disables debug
// - secure-user debug field set by enable, cleared by disable; 1 invasive, 2 not
// - global event gate resets 0, hardware or on/off instructions; moves fault
// - gate on accepts current-level events; secure mode drops non-secure events
// - pipeline guard changed only by its three instructions; protected by default
// - five-bit memory tag updated only by the tag-update instruction
// - priority resets to 1FFh, set by instruction; moves raise an exception
// - triple-fault priority entered only from the double-fault priority
// - handler flag set on event entry, cleared by permitted handler return
// - execution level resets to secure supervisor; changes only on core events
// - branch-back instruction branches to the held return pointer
// - call loads return pointer with the next packet address
// - triple fault also copies current address into return pointer
// - move to return pointer needs top sixteen bits all zero or one
// - move to return pointer needs two low bits zero
// - read-only register shows 48-bit address of the E1 fetch packet
// - predictor-disable bit at 0, reset 0, turns prediction off
// - float config: flush bit 4 resets 1, two-bit rounding select
module ctsc_regs
  import ctsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // straps from pins
  input wire logic endian_big,
  input wire logic accel_present,
  // control-register move
  input wire logic mv_valid,
  input wire logic mv_write,
  input wire logic [2:0] mv_sel,
  input wire logic [63:0] mv_wdata,
  output logic mv_rvalid,
  output logic [63:0] mv_rdata,
  output logic mv_exc_valid,
  output logic [1:0] mv_exc_cause,
  // dedicated instructions
  input wire logic accel_attach_instr,
  input wire logic accel_detach_instr,
  input wire logic addr_gen_attach_instr,
  input wire logic addr_gen_detach_instr,
  input wire logic [1:0] addr_gen_sel,
  input wire logic stream_eng_attach_instr,
  input wire logic stream_eng_detach_instr,
  input wire logic stream_eng_sel,
  input wire logic debug_block_instr,
  input wire logic debug_allow_instr,
  input wire logic secure_user_debug_on_instr,
  input wire logic [1:0] secure_user_debug_mode,
  input wire logic secure_user_debug_off_instr,
  input wire logic events_off_instr,
  input wire logic events_on_instr,
  input wire logic pipeline_guard_instr,
  input wire logic pipeline_guard_clear_instr,
  input wire logic pipeline_unguard_instr,
  input wire logic tag_update_instr,
  input wire logic [4:0] tag_value,
  input wire logic priority_set_instr,
  input wire logic [8:0] priority_value,
  input wire logic handler_return_instr,
  input wire logic handler_return_ok,
  input wire logic branch_back_instr,
  input wire logic call_instr,
  input wire logic [47:0] call_next_addr,
  // core events
  input wire logic hw_gate_wr,
  input wire logic hw_gate_val,
  input wire logic handler_entry,
  input wire logic level_update,
  input wire logic [2:0] level_value,
  input wire logic triple_fault,
  input wire logic [47:0] e1_fetch_addr,
  input wire logic evt_valid,
  input wire logic [2:0] evt_level,
  input wire logic evt_secure,
  // state out
  output logic [63:0] task_state_word,
  output logic branch_back_valid,
  output logic [63:0] branch_back_addr,
  output logic predictor_disable,
  output logic flush_denorm,
  output logic [1:0] round_select,
  output logic event_accept
);
  logic endian_s1_q, endian_q, pres_s1_q, pres_q;
  logic accel0_q;
  logic [AG_N-1:0] addr_gen_q;
  logic [SE_N-1:0] stream_eng_q;
  logic dbg_mask_q;
  logic [1:0] sud_q;
  logic gate_q;
  logic guard_q;
  logic [TAG_W-1:0] tag_q;
  logic [PRIO_W-1:0] prio_q;
  logic hdl_q;
  logic [LVL_W-1:0] lvl_q;
  logic [RP_W-1:0] rp_q;
  logic [RP_W-1:0] pc_q;
  logic predictor_disable_bit_q, ftz_q;
  logic [1:0] round_select_q;
  logic [63:0] tsw_d, rdata_d;
  logic mv_wr, tri_go;
  logic [1:0] cause_d;
  logic accept_q;

  ctsc_chk_if chk ();

  ctsc_rp_check u_rp_check (
    .c(chk.rp_chk)
  );

  ctsc_evt_gate u_evt_gate (
    .c(chk.evt_chk)
  );

  assign chk.clk = clk;
  assign chk.rst = rst;
  assign chk.rp_wdata = mv_wdata;
  assign chk.evt_valid = evt_valid;
  assign chk.evt_level = evt_level;
  assign chk.evt_secure = evt_secure;
  assign chk.gate = gate_q;
  assign chk.exec_level = lvl_q;
  assign mv_wr = mv_valid && mv_write;
  // triple fault honoured only from double fault
  assign tri_go = triple_fault && (prio_q == PRIO_DOUBLE);

  ////////////////////////////////////////////////////////////////////////////
  // straps: pins pass two flops before use
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      endian_s1_q <= 1'b0;
      endian_q <= 1'b0;
      pres_s1_q <= 1'b0;
      pres_q <= 1'b0;
    end
    else
    begin
      endian_s1_q <= endian_big;
      endian_q <= endian_s1_q;
      pres_s1_q <= accel_present;
      pres_q <= pres_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // attach state; move writes never reach these
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      accel0_q <= 1'b0;
      addr_gen_q <= '0;
      stream_eng_q <= '0;
    end
    else
    begin
      if (accel_detach_instr)
        accel0_q <= 1'b0;
      else if (accel_attach_instr)
        accel0_q <= 1'b1;
      if (addr_gen_detach_instr)
        addr_gen_q[addr_gen_sel] <= 1'b0;
      else if (addr_gen_attach_instr)
        addr_gen_q[addr_gen_sel] <= 1'b1;
      if (stream_eng_detach_instr)
        stream_eng_q[stream_eng_sel] <= 1'b0;
      else if (stream_eng_attach_instr)
        stream_eng_q[stream_eng_sel] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // debug controls
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dbg_mask_q <= 1'b0;
      sud_q <= SUD_OFF;
    end
    else
    begin
      if (debug_block_instr)
        dbg_mask_q <= 1'b1;
      else if (debug_allow_instr)
        dbg_mask_q <= 1'b0;
      // reserved encodings are not stored
      if (secure_user_debug_off_instr)
        sud_q <= SUD_OFF;
      else if (secure_user_debug_on_instr && (secure_user_debug_mode == SUD_INVASIVE
          || secure_user_debug_mode == SUD_NONINV))
        sud_q <= secure_user_debug_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event gate, pipeline guard, tag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gate_q <= 1'b0;
      guard_q <= GUARD_RST;
      tag_q <= '0;
    end
    else
    begin
      if (hw_gate_wr)
        gate_q <= hw_gate_val;
      else if (events_off_instr)
        gate_q <= 1'b0;
      else if (events_on_instr)
        gate_q <= 1'b1;
      if (pipeline_guard_clear_instr || pipeline_unguard_instr)
        guard_q <= 1'b0;
      else if (pipeline_guard_instr)
        guard_q <= 1'b1;
      if (tag_update_instr)
        tag_q <= tag_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority, handler flag, execution level
  always_ff @(posedge clk)
  begin
    if (rst)
      prio_q <= PRIO_RST;
    else if (tri_go)
      prio_q <= PRIO_TRIPLE;
    else if (priority_set_instr && (priority_value != PRIO_TRIPLE || prio_q == PRIO_DOUBLE))
      prio_q <= priority_value;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      hdl_q <= 1'b0;
    else if (handler_entry)
      hdl_q <= 1'b1;
    else if (handler_return_instr && handler_return_ok)
      hdl_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      lvl_q <= LVL_RST;
    else if (level_update)
      lvl_q <= level_value;
  end

  ////////////////////////////////////////////////////////////////////////////
  // return pointer: triple fault beats call beats move
  always_ff @(posedge clk)
  begin
    if (rst)
      rp_q <= '0;
    else if (tri_go)
      rp_q <= pc_q;
    else if (call_instr)
      rp_q <= {1'b0, call_next_addr};
    else if (mv_wr && mv_sel == SEL_RP && chk.rp_ok)
      rp_q <= mv_wdata[RP_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      branch_back_valid <= 1'b0;
      branch_back_addr <= '0;
    end
    else
    begin
      branch_back_valid <= branch_back_instr;
      branch_back_addr <= {{(64-RP_W){1'b0}}, rp_q};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pc_q <= '0;
    else
      pc_q <= {1'b0, e1_fetch_addr};
  end

  ////////////////////////////////////////////////////////////////////////////
  // predictor and float configuration
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      predictor_disable_bit_q <= PREDICTOR_DISABLE_BIT_RST;
      ftz_q <= FTZ_RST;
      round_select_q <= ROUND_SELECT_RST;
    end
    else if (mv_wr && mv_sel == SEL_BP)
      predictor_disable_bit_q <= mv_wdata[PREDICTOR_DISABLE_BIT_BIT];
    else if (mv_wr && mv_sel == SEL_FP)
    begin
      ftz_q <= mv_wdata[FTZ_BIT];
      round_select_q <= mv_wdata[ROUND_SELECT_LO +: 2];
    end
  end

  assign predictor_disable = predictor_disable_bit_q;
  assign flush_denorm = ftz_q;
  assign round_select = round_select_q;

  ////////////////////////////////////////////////////////////////////////////
  // state word and move reads
  always_comb
  begin
    tsw_d = '0;
    tsw_d[TSW_ENDIAN] = endian_q;
    tsw_d[TSW_ACCEL_PRES] = pres_q;
    tsw_d[TSW_ACCEL0] = accel0_q;
    tsw_d[TSW_AG_LO +: AG_N] = addr_gen_q;
    tsw_d[TSW_SE_LO +: SE_N] = stream_eng_q;
    tsw_d[TSW_DBG_MASK] = dbg_mask_q;
    tsw_d[TSW_SUD_LO +: 2] = sud_q;
    tsw_d[TSW_GATE] = gate_q;
    tsw_d[TSW_GUARD] = guard_q;
    tsw_d[TSW_TAG_LO +: TAG_W] = tag_q;
    tsw_d[TSW_PRIO_LO +: PRIO_W] = prio_q;
    tsw_d[TSW_HDL] = hdl_q;
    tsw_d[TSW_LVL_LO +: LVL_W] = lvl_q;
  end

  assign task_state_word = tsw_d;

  always_comb
  begin
    rdata_d = '0;
    case (mv_sel)
      SEL_TSW: rdata_d = tsw_d;
      SEL_RP: rdata_d[RP_W-1:0] = rp_q;
      SEL_PC: rdata_d[RP_W-1:0] = pc_q;
      SEL_BP: rdata_d[PREDICTOR_DISABLE_BIT_BIT] = predictor_disable_bit_q;
      SEL_FP:
      begin
        rdata_d[FTZ_BIT] = ftz_q;
        rdata_d[ROUND_SELECT_LO +: 2] = round_select_q;
      end
      default: rdata_d = '0;
    endcase
  end

  // writes to the state word hit gate, priority and handler fields: fault
  always_comb
  begin
    cause_d = EXC_NONE;
    if (mv_valid)
    begin
      case (mv_sel)
        SEL_TSW: cause_d = mv_write ? EXC_PRIV : EXC_NONE;
        SEL_RP: cause_d = (mv_write && !chk.rp_ok) ? EXC_WRITE : EXC_NONE;
        SEL_PC: cause_d = mv_write ? EXC_PRIV : EXC_NONE;
        SEL_BP, SEL_FP: cause_d = EXC_NONE;
        default: cause_d = EXC_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mv_rvalid <= 1'b0;
      mv_rdata <= '0;
      mv_exc_valid <= 1'b0;
      mv_exc_cause <= EXC_NONE;
    end
    else
    begin
      mv_rvalid <= mv_valid && !mv_write && cause_d == EXC_NONE;
      mv_rdata <= (mv_valid && !mv_write) ? rdata_d : '0;
      mv_exc_valid <= cause_d != EXC_NONE;
      mv_exc_cause <= cause_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      accept_q <= 1'b0;
    else
      accept_q <= chk.accept;
  end

  assign event_accept = accept_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_in_double;
    prio_q == PRIO_DOUBLE;
  endsequence
  sequence s_tri_req;
    triple_fault;
  endsequence

  chk_accel_attach: assert property (accel_attach_instr && !accel_detach_instr
    |=> accel0_q) else $error("attach did not set accelerator bit");
  chk_accel_move: assert property (mv_wr && !accel_attach_instr && !accel_detach_instr
    |=> $stable(accel0_q)) else $error("move changed accelerator bit");
  chk_tsw_write_exc: assert property (mv_wr && mv_sel == SEL_TSW
    |=> mv_exc_valid && mv_exc_cause == EXC_PRIV && ($stable(gate_q) || $past(hw_gate_wr)
    || $past(events_on_instr) || $past(events_off_instr)))
    else $error("state word move did not fault");
  chk_triple_from_double: assert property ($changed(prio_q) && prio_q == PRIO_TRIPLE
    |-> $past(prio_q) == PRIO_DOUBLE) else $error("triple fault not from double fault");
  chk_triple_rp: assert property (s_in_double ##0 s_tri_req
    |=> prio_q == PRIO_TRIPLE && rp_q == $past(pc_q)) else $error("triple fault entry wrong");
  chk_call_load: assert property (call_instr && !tri_go
    |=> rp_q == {1'b0, $past(call_next_addr)}) else $error("call did not load pointer");
  chk_rp_reject: assert property (mv_wr && mv_sel == SEL_RP && !chk.rp_ok && !call_instr
    && !tri_go |=> $stable(rp_q) && mv_exc_cause == EXC_WRITE)
    else $error("bad pointer write committed");
  chk_branch_back: assert property (branch_back_instr
    |=> branch_back_valid && branch_back_addr[RP_W-1:0] == $past(rp_q))
    else $error("branch-back address wrong");
  chk_guard_move: assert property (mv_wr && !pipeline_guard_instr && !pipeline_unguard_instr
    && !pipeline_guard_clear_instr |=> $stable(guard_q))
    else $error("move changed pipeline guard");
  chk_level_hold: assert property (!level_update |=> $stable(lvl_q))
    else $error("execution level changed without cause");
endmodule : ctsc_regs
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top import ctsc_pkg::*;;
  logic clk, rst, endian_big, accel_present, mv_valid, mv_write, mv_rvalid, mv_exc_valid;
  logic [2:0] mv_sel, level_value, evt_level;
  logic [63:0] mv_wdata, mv_rdata, task_state_word, branch_back_addr, s_rd, s_ba;
  logic [1:0] mv_exc_cause, addr_gen_sel, secure_user_debug_mode, round_select, s_ec;
  logic branch_back_valid, predictor_disable, flush_denorm, event_accept;
  logic accel_attach_instr, accel_detach_instr, addr_gen_attach_instr, addr_gen_detach_instr;
  logic stream_eng_attach_instr, stream_eng_detach_instr, stream_eng_sel, debug_block_instr;
  logic debug_allow_instr, secure_user_debug_on_instr, secure_user_debug_off_instr;
  logic events_off_instr, events_on_instr, pipeline_guard_instr, pipeline_guard_clear_instr;
  logic pipeline_unguard_instr, tag_update_instr, priority_set_instr, handler_return_instr;
  logic handler_return_ok, branch_back_instr, call_instr, hw_gate_wr, hw_gate_val;
  logic handler_entry, level_update, triple_fault, evt_valid, evt_secure;
  logic s_rv, s_ev, s_bv, s_acc;
  logic [4:0] tag_value;
  logic [8:0] priority_value;
  logic [47:0] call_next_addr, e1_fetch_addr;
  logic [63:0] t;
  int fail_count, n_checks, cyc_n;
  typedef struct {int o; int a; int lo; int w; int e;} ctsc_row_s;
  // op, argument, field low bit, field width, expected field value
  ctsc_row_s rows [28] = '{'{0,0,48,1,1}, '{2,3,43,1,1}, '{2,0,40,1,1}, '{3,3,43,1,0},
    '{4,1,33,1,1}, '{4,0,32,1,1}, '{5,1,33,1,0}, '{6,0,28,1,1}, '{7,0,28,1,0},
    '{8,2,26,2,2}, '{8,3,26,2,2}, '{9,0,26,2,0}, '{8,1,26,2,1}, '{11,0,25,1,1},
    '{10,0,25,1,0}, '{20,1,25,1,1}, '{14,0,24,1,0}, '{12,0,24,1,1}, '{13,0,24,1,0},
    '{15,21,19,5,21},
    '{16,255,8,9,255}, '{16,510,8,9,255}, '{17,3,0,3,3}, '{18,0,3,1,1}, '{19,0,3,1,1},
    '{19,1,3,1,0}, '{1,0,48,1,0}, '{11,0,25,1,1}};

  ctsc_regs dut (.*);

  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [63:0] fld(input int lo, input int w);
    return (task_state_word >> lo) & ((64'h1 << w) - 64'h1);
  endfunction : fld

  task automatic clr;
    {mv_valid, evt_valid, accel_attach_instr, accel_detach_instr, addr_gen_attach_instr} = '0;
    {addr_gen_detach_instr, stream_eng_attach_instr, stream_eng_detach_instr} = '0;
    {debug_block_instr, debug_allow_instr, secure_user_debug_on_instr} = '0;
    {secure_user_debug_off_instr, events_off_instr, events_on_instr, hw_gate_wr} = '0;
    {pipeline_guard_instr, pipeline_guard_clear_instr, pipeline_unguard_instr} = '0;
    {tag_update_instr, priority_set_instr, handler_return_instr, handler_entry} = '0;
    {level_update, branch_back_instr, call_instr, triple_fault} = '0;
  endtask : clr

  // one taking edge, snapshot of the one-cycle answers, then an idle cycle
  task automatic go;
    @(posedge clk);
    @(negedge clk);
    s_rv = mv_rvalid;
    s_rd = mv_rdata;
    s_ev = mv_exc_valid;
    s_ec = mv_exc_cause;
    s_bv = branch_back_valid;
    s_ba = branch_back_addr;
    s_acc = event_accept;
    clr();
    @(negedge clk);
  endtask : go

  task automatic op(input int o, input int a);
    addr_gen_sel = a[1:0];
    stream_eng_sel = a[0];
    secure_user_debug_mode = a[1:0];
    tag_value = a[4:0];
    priority_value = a[8:0];
    level_value = a[2:0];
    handler_return_ok = a[0];
    hw_gate_val = a[0];
    evt_level = a[2:0];
    evt_secure = a[3];
    case (o)
      0: accel_attach_instr = 1;
      1: accel_detach_instr = 1;
      2: addr_gen_attach_instr = 1;
      3: addr_gen_detach_instr = 1;
      4: stream_eng_attach_instr = 1;
      5: stream_eng_detach_instr = 1;
      6: debug_block_instr = 1;
      7: debug_allow_instr = 1;
      8: secure_user_debug_on_instr = 1;
      9: secure_user_debug_off_instr = 1;
      10: events_off_instr = 1;
      11: events_on_instr = 1;
      12: pipeline_guard_instr = 1;
      13: pipeline_guard_clear_instr = 1;
      14: pipeline_unguard_instr = 1;
      15: tag_update_instr = 1;
      16: priority_set_instr = 1;
      17: level_update = 1;
      18: handler_entry = 1;
      19: handler_return_instr = 1;
      20: hw_gate_wr = 1;
      21: branch_back_instr = 1;
      22: call_instr = 1;
      23: triple_fault = 1;
      default: evt_valid = 1;
    endcase
  endtask : op

  task automatic mv(input logic w, input logic [2:0] s, input logic [63:0] d,
    input logic [1:0] ec, input logic [63:0] rd);
    mv_valid = 1;
    mv_write = w;
    mv_sel = s;
    mv_wdata = d;
    go();
    chk("exc_valid", 64'(ec != EXC_NONE), 64'(s_ev));
    if (ec != EXC_NONE)
      chk("exc_cause", 64'(ec), 64'(s_ec));
    chk("rvalid", 64'(!w && ec == EXC_NONE), 64'(s_rv));
    if (!w && ec == EXC_NONE)
      chk("rdata", rd, s_rd);
  endtask : mv

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc_n++;
    // run needs well under 1000 cycles
    if (cyc_n == 5000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    {rst, endian_big, accel_present, mv_write, mv_sel, mv_wdata} = '0;
    rst = 1;
    e1_fetch_addr = 48'h8765_4321_0ff0;
    call_next_addr = 48'h1234_5678_9abc;
    clr();
    op(24, 0);
    clr();
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 0;
    @(negedge clk);
    chk("tsw_reset", 64'h0000_0000_0101_ff05, task_state_word);
    chk("flush_reset", 1, 64'(flush_denorm));
    chk("predictor_disable_bit_reset", 0, 64'(predictor_disable));
    mv(0, SEL_FP, 0, EXC_NONE, 64'h0000_0000_0000_0010);
    foreach (rows[i])
    begin
      op(rows[i].o, rows[i].a);
      go();
      chk($sformatf("row%0d", i), 64'(rows[i].e), fld(rows[i].lo, rows[i].w));
    end
    // same-cycle conflicts: clearing and hardware writes take precedence
    op(0, 0);
    op(1, 0);
    go();
    chk("attach_detach", 0, fld(TSW_ACCEL0, 1));
    op(11, 0);
    op(20, 0);
    go();
    chk("hw_gate", 0, fld(TSW_GATE, 1));
    op(11, 0);
    go();
    for (int i = 0; i < 5; i++)
    begin
      // level 3 then 5; index 4 leaves a secure level with gate off
      if (i == 2)
        op(17, 5);
      if (i == 4)
        op(10, 0);
      if (i == 2 || i == 4)
        go();
      op(24, (i == 1) ? 2 : (i == 3 || i == 4) ? 13 : (i == 2) ? 5 : 3);
      go();
      chk("accept", 64'(i == 0 || i == 3), 64'(s_acc));
    end
    t = task_state_word;
    mv(1, SEL_TSW, '1, EXC_PRIV, 0);
    mv(0, SEL_TSW, 0, EXC_NONE, t);
    for (int m = 0; m < 4; m++)
    begin
      mv(1, SEL_FP, 64'((m & 1) << 4 | m), EXC_NONE, 0);
      chk("float_cfg", 64'((m & 1) << 4 | m), 64'({flush_denorm, 2'b00, round_select}));
    end
    mv(1, SEL_BP, 1, EXC_NONE, 0);
    chk("predictor_disable_bit", 1, 64'(predictor_disable));
    mv(0, SEL_BP, 0, EXC_NONE, 1);
    mv(1, SEL_RP, 64'hffff_8000_0000_1234, EXC_NONE, 0);
    mv(1, SEL_RP, 64'h0001_0000_0000_0000, EXC_WRITE, 0);
    mv(1, SEL_RP, 64'h0000_0000_0000_1236, EXC_WRITE, 0);
    mv(0, SEL_RP, 0, EXC_NONE, 64'h0001_8000_0000_1234);
    mv(0, 3'h5, 0, EXC_UNMAPPED, 0);
    mv(1, 3'h7, 0, EXC_UNMAPPED, 0);
    op(21, 0);
    go();
    chk("bb_valid", 1, 64'(s_bv));
    chk("bb_addr", 64'h0001_8000_0000_1234, s_ba);
    op(22, 0);
    go();
    mv(0, SEL_RP, 0, EXC_NONE, 64'h0000_1234_5678_9abc);
    e1_fetch_addr = 48'h0000_0fed_cba8;
    op(23, 0);
    go();
    chk("no_triple", 64'(PRIO_TASK), fld(TSW_PRIO_LO, PRIO_W));
    mv(0, SEL_PC, 0, EXC_NONE, 64'h0000_0000_0fed_cba8);
    mv(1, SEL_PC, 0, EXC_PRIV, 0);
    mv(0, SEL_RP, 0, EXC_NONE, 64'h0000_1234_5678_9abc);
    op(16, 511);
    go();
    op(23, 0);
    go();
    chk("triple", 64'(PRIO_TRIPLE), fld(TSW_PRIO_LO, PRIO_W));
    mv(0, SEL_RP, 0, EXC_NONE, 64'h0000_0000_0fed_cba8);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    @(negedge clk);
    chk("tsw_rerst", 64'h0000_0000_0101_ff05, task_state_word);
    chk("fp_rerst", 64'h10, 64'({flush_denorm, 2'b00, round_select}));
    chk("bp_rerst", 0, 64'(predictor_disable));
    endian_big = 1;
    accel_present = 1;
    repeat (4) @(negedge clk);
    chk("endian", 1, fld(TSW_ENDIAN, 1));
    chk("accel_pres", 1, fld(TSW_ACCEL_PRES, 1));
    results();
  end
endmodule : tb_top
`default_nettype wire
